// >>> rtl/bank0_sfr_map.vh
// Address map, field positions and reset values of the bank 0 special registers
`ifndef BANK0_SFR_MAP_VH
`define BANK0_SFR_MAP_VH
`define A_INDIRECT      7'h00
`define A_TIMER0        7'h01
`define A_PC_LOW        7'h02
`define A_STATUS        7'h03
`define A_POINTER       7'h04
`define A_PORT_A        7'h05
`define A_PORT_B        7'h06
`define A_PORT_C        7'h07
`define A_PC_LATCH      7'h0a
`define A_INT_CTRL      7'h0b
`define A_PERIPH_FLAGS  7'h0c
`define A_TIMER1_LOW    7'h0e
`define A_TIMER1_HIGH   7'h0f
`define A_TIMER1_CTRL   7'h10
`define A_TIMER2        7'h11
`define A_TIMER2_CTRL   7'h12
`define A_SERIAL_BUF    7'h13
`define A_SERIAL_CTRL   7'h14
`define A_CAPTURE_LOW   7'h15
`define A_CAPTURE_HIGH  7'h16
`define A_CAPTURE_CTRL  7'h17
`define A_CONV_RESULT   7'h1e
`define A_CONV_CTRL     7'h1f
`define A_GPR_FIRST     7'h20
// Implemented-bit masks
`define M_PORT_A        8'h3f
`define M_PC_LATCH      8'h1f
`define M_PERIPH_FLAGS  8'h4f
`define M_PERIPH_NOCONV 8'h0f
`define M_TIMER1_CTRL   8'h3f
`define M_TIMER2_CTRL   8'h7f
`define M_CAPTURE_CTRL  8'h3f
`define M_CONV_CTRL     8'hfd
// Reset values
`define R_ZERO          8'h00
`define R_STATUS_POR    8'h18
`define R_STATUS_KEEP   8'h07
// Status bit positions
`define S_TIMEOUT       4
`define S_POWERDOWN     3
`endif

// >>> rtl/gpr_ram.v
// General purpose static RAM of one bank, registered read data
`default_nettype none
module gpr_ram (
    input  wire       clk,   // Core clock
    input  wire       we,    // Write strobe
    input  wire [6:0] waddr, // Write address
    input  wire [7:0] wdata, // Write data
    input  wire [6:0] raddr, // Read address
    output reg  [7:0] rdata  // Registered read data
);
    reg [7:0] mem [0:127];

    // Write and registered read
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // gpr_ram
`default_nettype wire

// >>> rtl/bank0_special_register_map.v
// Bank 0 special function register decode with port latches and general purpose RAM
`include "bank0_sfr_map.vh"
`default_nettype none
module bank0_special_register_map (
    input  wire       clk,          // Core clock
    input  wire       rst,          // Any reset, synchronous
    input  wire       power_reset,  // With rst: power-on or brown-out
    input  wire       cause_timeout,// Time-out bit value for a reset without power_reset
    input  wire       cause_pwrdown,// Power-down bit value for a reset without power_reset
    input  wire       has_converter,// Converter present on this variant
    input  wire       rd,           // Data read strobe
    input  wire       wr,           // Data write strobe
    input  wire [7:0] addr,         // File address, bit 7 is bank select
    input  wire [7:0] wdata,        // Write data
    output reg  [7:0] rdata,        // Read data, one cycle after rd
    input  wire       pc_upper_load,// Program counter upper byte load
    output reg  [12:0] pc_ff,       // Program counter
    input  wire [7:0] status_flags_in,// ALU flag update value
    input  wire       status_flags_we,// ALU flag update strobe
    output wire [7:0] status_out,   // Status register
    output wire [7:0] int_ctrl_out, // Interrupt control register
    input  wire [5:0] pin_a,        // Port A pin levels
    input  wire [7:0] pin_b,        // Port B pin levels
    input  wire [7:0] pin_c,        // Port C pin levels
    output wire [5:0] port_a_out,   // Port A output latch
    output wire [7:0] port_b_out,   // Port B output latch
    output wire [7:0] port_c_out,   // Port C output latch
    output wire [5:0] port_a_oe,    // Port A drive enable
    output wire [7:0] port_b_oe,    // Port B drive enable
    output wire [7:0] port_c_oe     // Port C drive enable
);
    reg  [7:0] status_ff;
    reg  [7:0] pointer_ff;
    reg  [4:0] pc_latch_ff;
    reg  [7:0] int_ctrl_ff;
    reg  [7:0] periph_ff;
    reg  [5:0] lat_a_ff;
    reg  [7:0] lat_b_ff;
    reg  [7:0] lat_c_ff;
    reg  [5:0] dir_a_ff;
    reg  [7:0] dir_b_ff;
    reg  [7:0] dir_c_ff;
    reg  [7:0] sfr_q_ff;
    reg  [6:0] rd_off_ff;
    wire [6:0] ram_raddr;
    wire [31:0] store_sel;
    wire [255:0] store_flat;
    reg  [7:0] nxt_rdata;
    reg        ram_sel_ff;
    wire [7:0] ram_q;
    wire [7:0] eff_addr;
    wire [6:0] off;
    wire       bank1;
    wire       gpr;
    wire       is_plain;
    wire [7:0] flag_mask;
    genvar     i;

    // Plain stores cleared by every reset, and those cleared by power resets only
    localparam [31:0] CLR_ANY   = (32'h0000_0001 << `A_TIMER2) | (32'h0000_0001 << `A_TIMER2_CTRL) |
                                  (32'h0000_0001 << `A_SERIAL_CTRL) | (32'h0000_0001 << `A_CAPTURE_CTRL) |
                                  (32'h0000_0001 << `A_CONV_CTRL);
    localparam [31:0] CLR_POWER = 32'h0000_0001 << `A_TIMER1_CTRL;

    // Indirect location redirects through the pointer
    assign eff_addr = (addr[6:0] == `A_INDIRECT) ? pointer_ff : addr;
    assign off      = eff_addr[6:0];
    assign bank1    = eff_addr[7];
    assign gpr      = (off >= `A_GPR_FIRST);
    assign flag_mask = has_converter ? `M_PERIPH_FLAGS : `M_PERIPH_NOCONV;

    // Timer, serial, capture and converter data stores
    assign is_plain = ~bank1 & ((off == `A_TIMER0) | ((off >= `A_TIMER1_LOW) & (off <= `A_CAPTURE_CTRL)) |
                      (has_converter & ((off == `A_CONV_RESULT) | (off == `A_CONV_CTRL))));

    gpr_ram u_ram (
        .clk   (clk),
        .we    (wr & gpr & ~(addr[6:0] == `A_INDIRECT && pointer_ff[6:0] == `A_INDIRECT)),
        .waddr (off),
        .wdata (wdata),
        .raddr (ram_raddr),
        .rdata (ram_q)
    );

    // Ports: latch drives pin only when direction says output
    assign port_a_out = lat_a_ff;
    assign port_b_out = lat_b_ff;
    assign port_c_out = lat_c_ff;
    assign port_a_oe  = ~dir_a_ff;
    assign port_b_oe  = ~dir_b_ff;
    assign port_c_oe  = ~dir_c_ff;
    assign status_out   = status_ff;
    assign int_ctrl_out = int_ctrl_ff;

    // Implemented-bit mask for plain stores
    function [7:0] plain_mask;
        input [6:0] a;
        begin
            case (a)
                `A_TIMER1_CTRL:  plain_mask = `M_TIMER1_CTRL;
                `A_TIMER2_CTRL:  plain_mask = `M_TIMER2_CTRL;
                `A_CAPTURE_CTRL: plain_mask = `M_CAPTURE_CTRL;
                `A_CONV_CTRL:    plain_mask = `M_CONV_CTRL;
                default:         plain_mask = 8'hff;
            endcase
        end
    endfunction

    // Direction registers, any reset turns every pin to input
    always @(posedge clk) begin
        if (rst) begin
            dir_a_ff <= 6'h3f;
            dir_b_ff <= 8'hff;
            dir_c_ff <= 8'hff;
        end else if (wr && !gpr && bank1) begin
            case (off)
                `A_PORT_A: begin
                    dir_a_ff <= wdata[5:0];
                end
                `A_PORT_B: begin
                    dir_b_ff <= wdata;
                end
                `A_PORT_C: begin
                    dir_c_ff <= wdata;
                end
                default: begin
                    dir_a_ff <= dir_a_ff;
                end
            endcase
        end
    end

    // Output latches, port A clears all but bit 4, ports B and C keep contents
    always @(posedge clk) begin
        if (rst) begin
            lat_a_ff <= {1'b0, lat_a_ff[4], 4'h0};
        end else if (wr && !gpr && !bank1) begin
            case (off)
                `A_PORT_A: begin
                    lat_a_ff <= wdata[5:0];
                end
                `A_PORT_B: begin
                    lat_b_ff <= wdata;
                end
                `A_PORT_C: begin
                    lat_c_ff <= wdata;
                end
                default: begin
                    lat_a_ff <= lat_a_ff;
                end
            endcase
        end
    end

    // Program counter, low byte written directly, upper bits only from the latch
    always @(posedge clk) begin
        if (rst) begin
            pc_ff <= 13'h0000;
        end else begin
            if (pc_upper_load) begin
                pc_ff[12:8] <= pc_latch_ff;
            end
            if (wr && !gpr && off == `A_PC_LOW) begin
                pc_ff[7:0] <= wdata;
            end
        end
    end

    // Holding latch for program counter bits 12 to 8
    always @(posedge clk) begin
        if (rst) begin
            pc_latch_ff <= 5'h00;
        end else if (wr && !gpr && off == `A_PC_LATCH) begin
            pc_latch_ff <= wdata[4:0];
        end
    end

    // Indirect pointer, no reset, contents survive every reset
    always @(posedge clk) begin
        if (!rst && wr && !gpr && off == `A_POINTER) begin
            pointer_ff <= wdata;
        end
    end

    // Interrupt control, bit 0 survives reset
    always @(posedge clk) begin
        if (rst) begin
            int_ctrl_ff <= {7'h00, int_ctrl_ff[0]};
        end else if (wr && !gpr && off == `A_INT_CTRL) begin
            int_ctrl_ff <= wdata;
        end
    end

    // Status, cause bits from the reset source, ALU flags win over software
    always @(posedge clk) begin
        if (rst) begin
            if (power_reset) begin
                status_ff <= `R_STATUS_POR | (status_ff & `R_STATUS_KEEP);
            end else begin
                status_ff <= {3'h0, cause_timeout, cause_pwrdown, status_ff[2:0]};
            end
        end else if (wr && !gpr && off == `A_STATUS) begin
            status_ff[7:5] <= wdata[7:5];
            if (status_flags_we) begin
                status_ff[2:0] <= status_flags_in[2:0];
            end else begin
                status_ff[2:0] <= wdata[2:0];
            end
        end else if (status_flags_we) begin
            status_ff[2:0] <= status_flags_in[2:0];
        end
    end

    // Peripheral flags, bank 0 only, absent bits never stored
    always @(posedge clk) begin
        if (rst) begin
            periph_ff <= `R_ZERO;
        end else if (wr && !gpr && !bank1 && off == `A_PERIPH_FLAGS) begin
            periph_ff <= wdata & flag_mask;
        end
    end

    // One-hot select of the addressed plain store
    assign store_sel = 32'h0000_0001 << off[4:0];

    // Plain stores, one per file address; entries with no register are never written
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_store
            reg [7:0] store_ff;
            // Reset class of this entry, writes through the implemented-bit mask
            always @(posedge clk) begin
                if (rst) begin
                    if (CLR_ANY[i] || (CLR_POWER[i] && power_reset)) begin
                        store_ff <= `R_ZERO;
                    end
                end else if (wr && !gpr && is_plain && store_sel[i]) begin
                    store_ff <= wdata & plain_mask(off);
                end
            end
            assign store_flat[8 * i +: 8] = store_ff;
        end
    endgenerate

    // Read decode, unmapped locations and bits return zero
    always @* begin
        nxt_rdata = `R_ZERO;
        case (off)
            `A_INDIRECT: begin
                nxt_rdata = `R_ZERO;
            end
            `A_PC_LOW: begin
                nxt_rdata = pc_ff[7:0];
            end
            `A_STATUS: begin
                nxt_rdata = status_ff;
            end
            `A_POINTER: begin
                nxt_rdata = pointer_ff;
            end
            `A_PC_LATCH: begin
                nxt_rdata = {3'h0, pc_latch_ff};
            end
            `A_INT_CTRL: begin
                nxt_rdata = int_ctrl_ff;
            end
            `A_PORT_A: begin
                if (bank1) begin
                    nxt_rdata = {2'h0, dir_a_ff};
                end else begin
                    nxt_rdata = {2'h0, pin_a};
                end
            end
            `A_PORT_B: begin
                if (bank1) begin
                    nxt_rdata = dir_b_ff;
                end else begin
                    nxt_rdata = pin_b;
                end
            end
            `A_PORT_C: begin
                if (bank1) begin
                    nxt_rdata = dir_c_ff;
                end else begin
                    nxt_rdata = pin_c;
                end
            end
            `A_PERIPH_FLAGS: begin
                if (bank1) begin
                    nxt_rdata = `R_ZERO;
                end else begin
                    nxt_rdata = periph_ff & flag_mask;
                end
            end
            default: begin
                if (is_plain) begin
                    nxt_rdata = store_flat[{off[4:0], 3'h0} +: 8] & plain_mask(off);
                end
            end
        endcase
    end

    // Held read address keeps the RAM output standing after the strobe
    assign ram_raddr = rd ? off : rd_off_ff;

    // Registered special register data and RAM source flag
    always @(posedge clk) begin
        if (rst) begin
            ram_sel_ff <= 1'b0;
            rd_off_ff  <= 7'h00;
            sfr_q_ff   <= `R_ZERO;
        end else if (rd) begin
            ram_sel_ff <= gpr;
            rd_off_ff  <= off;
            sfr_q_ff   <= nxt_rdata;
        end
    end

    // Read data from RAM or special register, both sources are flip-flops
    always @* begin
        if (ram_sel_ff) begin
            rdata = ram_q;
        end else begin
            rdata = sfr_q_ff;
        end
    end
endmodule // bank0_special_register_map
`default_nettype wire

// >>> bench/bank0_map_monitor.sv
// Port checker of the bank 0 register map
`default_nettype none
module bank0_map_monitor (
    input wire logic        clk,           // Core clock
    input wire logic        rst,           // Reset
    input wire logic        power_reset,   // Power cause
    input wire logic        cause_timeout, // Time-out cause
    input wire logic        cause_pwrdown, // Power-down cause
    input wire logic        rd,            // Read strobe
    input wire logic        wr,            // Write strobe
    input wire logic [7:0]  addr,          // Address
    input wire logic [7:0]  wdata,         // Write data
    input wire logic [7:0]  rdata,         // Read data
    input wire logic        pc_upper_load, // PC load
    input wire logic [12:0] pc_ff,         // PC
    input wire logic [7:0]  status_out,    // Status
    input wire logic [5:0]  pin_a,         // Port A pins
    input wire logic [5:0]  port_a_out,    // Port A latch
    input wire logic [5:0]  port_a_oe,     // Port A enable
    input wire logic [7:0]  port_b_oe,     // Port B enable
    input wire logic [7:0]  port_c_oe      // Port C enable
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] lat_ff; // Shadow PC latch
    logic [7:0] ptr_ff; // Shadow indirect pointer
    logic [6:0] eff;    // Address after indirection
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Address after indirection through the shadow pointer
    assign eff = (addr[6:0] == 7'h00) ? ptr_ff[6:0] : addr[6:0];
    // Shadows of the pointer and the PC upper write buffer, both banks
    always @(posedge clk) begin
        if (!rst && wr && eff == 7'h04) begin
            ptr_ff <= wdata;
        end
        if (rst) begin
            lat_ff <= 5'h00;
        end else if (wr && eff == 7'h0a) begin
            lat_ff <= wdata[4:0];
        end
    end
    unmapped_zero_a: assert property (rd && !addr[7] && (addr[6:0] inside {7'h08, 7'h09, 7'h0d, [7'h18:7'h1d]})
        |=> rdata == 8'h00) else $error("unmapped read not zero");
    dir_input_a: assert property ($past(rst) |-> (port_a_oe == 6'h00) && (port_b_oe == 8'h00)
        && (port_c_oe == 8'h00)) else $error("port drives after reset");
    latch_clear_a: assert property ($past(rst) |-> {port_a_out[5], port_a_out[3:0]} == 5'h00)
        else $error("latch not cleared");
    status_por_a: assert property ($past(rst) && $past(power_reset) |-> status_out[7:3] == 5'h03)
        else $error("status power value");
    status_other_a: assert property ($past(rst) && !$past(power_reset)
        |-> status_out[7:3] == {3'h0, $past(cause_timeout), $past(cause_pwrdown)}) else $error("status cause bits");
    pc_load_a: assert property (pc_upper_load |=> pc_ff[12:8] == $past(lat_ff)) else $error("pc upper load");
    pin_read_a: assert property (rd && addr == 8'h05 |=> rdata == {2'b00, $past(pin_a)}) else $error("pin read");
    port_write_a: assert property (wr && addr == 8'h05 |=> port_a_out == $past(wdata[5:0]))
        else $error("latch write");
endmodule // bank0_map_monitor
bind bank0_special_register_map bank0_map_monitor i_mon (.clk, .rst, .power_reset, .cause_timeout, .cause_pwrdown,
    .rd, .wr, .addr, .wdata, .rdata, .pc_upper_load, .pc_ff, .status_out, .pin_a, .port_a_out, .port_a_oe,
    .port_b_oe, .port_c_oe);
`default_nettype wire

// >>> bench/bank0_special_register_map_test.sv
// Directed test of the bank 0 register map
`default_nettype none
module bank0_special_register_map_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, power_reset, cause_timeout, cause_pwrdown, has_converter, rd, wr, pc_upper_load;
    logic        status_flags_we;
    logic [7:0]  addr, wdata, rdata, status_flags_in, status_out, int_ctrl_out, pin_b, pin_c;
    logic [7:0]  port_b_out, port_c_out, port_b_oe, port_c_oe;
    logic [5:0]  pin_a, port_a_out, port_a_oe;
    logic [12:0] pc_ff;
    int          bad_count, comparisons;
    logic [7:0]  zr [9] = '{8'h02, 8'h0a, 8'h0c, 8'h10, 8'h11, 8'h12, 8'h14, 8'h17, 8'h1f};
    logic [7:0]  un [9] = '{8'h08, 8'h09, 8'h0d, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d};
    logic [15:0] mk [6] = '{16'h0a1f, 16'h0c4f, 16'h103f, 16'h127f, 16'h173f, 16'h1ffd};
    bank0_special_register_map i_dut (.clk, .rst, .power_reset, .cause_timeout, .cause_pwrdown, .has_converter,
        .rd, .wr, .addr, .wdata, .rdata, .pc_upper_load, .pc_ff, .status_flags_in, .status_flags_we, .status_out,
        .int_ctrl_out, .pin_a, .pin_b, .pin_c, .port_a_out, .port_b_out, .port_c_out, .port_a_oe, .port_b_oe,
        .port_c_oe);
    // Clock source
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Verdict and end of run
    task automatic print_verdict;
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("read %h", a), e, rdata);
    endtask
    task automatic do_reset(input logic p, input logic t, input logic d);
        @(posedge clk);
        rst <= 1'b1;
        power_reset <= p;
        cause_timeout <= t;
        cause_pwrdown <= d;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        power_reset <= 1'b0;
        #1;
    endtask
    // Main sequence
    initial begin
        {rst, power_reset, has_converter} = 3'b111;
        {cause_timeout, cause_pwrdown, rd, wr, pc_upper_load, status_flags_we} = 6'h00;
        {addr, wdata, status_flags_in} = 24'h00_0000;
        {pin_a, pin_b, pin_c} = 22'h2a_5cc3;
        do_reset(1'b1, 1'b0, 1'b0);
        chk("status", 8'h18, {status_out[7:3], 3'h0});
        chk("oe", 8'h00, {2'b00, port_a_oe} | port_b_oe | port_c_oe);
        chk("latch a", 8'h00, {3'h0, port_a_out[5], port_a_out[3:0]});
        foreach (zr[i]) rd_reg(zr[i], 8'h00);
        foreach (un[i]) begin wr_reg(un[i], 8'hff); rd_reg(un[i], 8'h00); end
        foreach (mk[i]) begin wr_reg(mk[i][15:8], 8'hff); rd_reg(mk[i][15:8], mk[i][7:0]); end
        @(posedge clk) has_converter <= 1'b0;
        rd_reg(8'h1e, 8'h00);
        rd_reg(8'h1f, 8'h00);
        rd_reg(8'h0c, 8'h0f);
        wr_reg(8'h84, 8'h0a);
        rd_reg(8'h04, 8'h0a);
        wr_reg(8'h00, 8'h15);
        rd_reg(8'h8a, 8'h15);
        rd_reg(8'h80, 8'h15);
        @(posedge clk) pc_upper_load <= 1'b1;
        @(posedge clk) pc_upper_load <= 1'b0;
        #1 chk("pc upper", 8'h15, {3'h0, pc_ff[12:8]});
        rd_reg(8'h05, 8'h2a);
        rd_reg(8'h06, 8'h5c);
        rd_reg(8'h07, 8'hc3);
        wr_reg(8'h05, 8'h3c);
        wr_reg(8'h06, 8'ha5);
        wr_reg(8'h07, 8'h96);
        wr_reg(8'h8b, 8'ha5);
        wr_reg(8'h86, 8'h00);
        chk("latch b", 8'ha5, port_b_out);
        chk("oe b", 8'hff, port_b_oe);
        chk("latch a", 8'h3c, {2'h0, port_a_out});
        chk("latch c", 8'h96, port_c_out);
        chk("int ctrl", 8'ha5, int_ctrl_out);
        rd_reg(8'h05, 8'h2a);
        @(posedge clk) begin status_flags_in <= 8'h05; status_flags_we <= 1'b1; end
        @(posedge clk) status_flags_we <= 1'b0;
        do_reset(1'b0, 1'b1, 1'b0);
        chk("status", 8'h15, status_out);
        chk("oe b", 8'h00, port_b_oe);
        chk("latch b", 8'ha5, port_b_out);
        chk("latch a", 8'h10, {2'h0, port_a_out});
        chk("int ctrl", 8'h01, int_ctrl_out);
        rd_reg(8'h04, 8'h0a);
        wr_reg(8'h83, 8'h22);
        rd_reg(8'h03, 8'h32);
        wr_reg(8'h20, 8'h5a);
        rd_reg(8'h20, 8'h5a);
        wr_reg(8'h84, 8'h7f);
        wr_reg(8'h80, 8'hc3);
        rd_reg(8'h7f, 8'hc3);
        rd_reg(8'h00, 8'hc3);
        print_verdict();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end
endmodule // bank0_special_register_map_test
`default_nettype wire
